// [dwwa_pkg.sv]
// Shared constants and types of the double-width receive word aligner
// Operation
// (R1) Accept one 16 or 20 bit word per clock
// (R2) Double width offers no automatic synchronization
// (R3) 16-bit configuration takes deserializer words directly
// (R4) Bypass mode passes data without any search
// (R5) Manual search starts right after reset release
// (R6) First pattern after reset locks regardless of enable
// (R7) Enable rising edge restarts search; fabric toggles
// (R8) Status carries the same latency as data
// (R9) First lock pulses pattern detect one clock
// (R10) Each pattern at locked boundary pulses detect
// (R11) Double-width sync holds until enable rising edge
// (R12) 20-bit width offers manual or bit-slip
// (R13) 20-bit patterns are 7, 10 or 20 bits
// (R14) 16-bit bit-slip patterns are 8 or 16 bits
// (R15) 10-bit bit-slip patterns are 7 or 10 bits
// (R16) 8-bit width allows only 16-bit patterns
// (R17) Bit-slip has no sync; detect pulses
// (R18) Single-width manual sync pulses on realignment
// (R19) 10-bit auto sync holds while conditions met
// (R20) Each slip request moves boundary one bit
// (R21) Reset clears boundary and holds status low
package dwwa_pkg;

    localparam int DWWA_MAX_W = 20;
    localparam int DWWA_LEN_W = 6;

    // Reset values of the alignment state
    localparam logic DWWA_RST_SEARCH = 1'b1;
    localparam logic DWWA_RST_SYNC = 1'b0;

    // Pattern lengths in bits
    localparam logic [5:0] DWWA_LEN_7 = 6'h07;
    localparam logic [5:0] DWWA_LEN_8 = 6'h08;
    localparam logic [5:0] DWWA_LEN_10 = 6'h0A;
    localparam logic [5:0] DWWA_LEN_16 = 6'h10;
    localparam logic [5:0] DWWA_LEN_20 = 6'h14;
    localparam logic [5:0] DWWA_LEN_32 = 6'h20;

    typedef enum logic [3:0] {
        DWWA_MODE_BYPASS = 4'h1,
        DWWA_MODE_MANUAL = 4'h2,
        DWWA_MODE_BITSLIP = 4'h4,
        DWWA_MODE_AUTO = 4'h8
    } dwwa_mode_t;

    typedef struct packed {
        logic [DWWA_MAX_W-1:0] data;
        logic sync;
        logic pdet;
    } dwwa_word_t;

endpackage

// [dwwa_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dwwa_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic [1:0] cnt;
        logic vld;
        logic rdy;
    } dwwa_buf_t;

    dwwa_buf_t st_q;
    dwwa_buf_t st_d;
    logic push;
    logic pop;

    always_comb
    begin
        st_d = st_q;
        push = in_valid_i && st_q.rdy;
        pop = st_q.vld && out_ready_i;
        case ({push, pop})
            2'b10:
            begin
                if (st_q.cnt == 2'h0)
                    st_d.head = in_data_i;
                else
                    st_d.tail = in_data_i;
                st_d.cnt = st_q.cnt + 2'h1;
            end
            2'b01:
            begin
                st_d.head = st_q.tail;
                st_d.cnt = st_q.cnt - 2'h1;
            end
            2'b11:
            begin
                // Only one word is held when both happen, so it moves out
                st_d.head = in_data_i;
            end
            default:
            begin
                st_d.cnt = st_q.cnt;
            end
        endcase
        st_d.vld = (st_d.cnt != 2'h0);
        st_d.rdy = (st_d.cnt != 2'h2);
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
            st_q.rdy <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign in_ready_o = st_q.rdy;
    assign out_valid_o = st_q.vld;
    assign out_data_o = st_q.head;

    a_buf_latency: assert property ( // (R8)
        @(posedge clock_i) disable iff (rst_i)
        (in_valid_i && in_ready_o && !out_valid_o)
            |=> (out_valid_o && out_data_o == $past(in_data_i)))
        else $error("buffered word did not appear one clock later");

    a_buf_hold: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (out_valid_o && !out_ready_i) |=> ($stable(out_data_o) && out_valid_o))
        else $error("stalled output word changed");

endmodule
`default_nettype wire

// [dwwa_word_aligner.sv]
// Receive word aligner with manual and bit-slip modes at every width, bypass below 20 bits and auto-sync at 8 and 10 bits
`timescale 1ns/1ps
`default_nettype none
module dwwa_word_aligner #(
    parameter int W = 16,
    parameter int ACQ_N = 4,
    parameter int LOSE_N = 4,
    parameter int GOOD_N = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire dwwa_pkg::dwwa_mode_t mode_i,
    input wire logic [2*W-1:0] pattern_i,
    input wire logic [dwwa_pkg::DWWA_LEN_W-1:0] pat_len_i,
    input wire logic align_en_i,
    input wire logic slip_i,
    input wire logic code_err_i,
    input wire logic rx_valid_i,
    input wire logic [W-1:0] rx_data_i,
    output logic rx_ready_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic sync_o,
    output logic pdet_o
);

    localparam int BW = $clog2(W);
    localparam int CW = 9;
    localparam int WORD_W = $bits(dwwa_pkg::dwwa_word_t);
    localparam logic DW = (W > 10);
    localparam logic LEVEL_EN = (W == 10);

    typedef struct packed {
        logic [2*W-1:0] hist;
        logic [BW-1:0] bnd;
        logic searching;
        logic sync_lvl;
        logic synced;
        logic en_prev;
        logic slip_prev;
        logic [CW-1:0] acq_cnt;
        logic [CW-1:0] err_cnt;
        logic [CW-1:0] good_cnt;
    } dwwa_state_t;

    dwwa_state_t st_q;
    dwwa_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Pattern length legality per interface width and mode

    function automatic logic len_ok(input dwwa_pkg::dwwa_mode_t md,
                                    input logic [5:0] len);
        logic ok;
        ok = 1'b0;
        if (W == 8)
            ok = (len == dwwa_pkg::DWWA_LEN_16); // (R16)
        else if (W == 10)
            ok = (len == dwwa_pkg::DWWA_LEN_7) ||
                 (len == dwwa_pkg::DWWA_LEN_10); // (R15) (R19)
        else if (W == 16)
        begin
            ok = (len == dwwa_pkg::DWWA_LEN_8) ||
                 (len == dwwa_pkg::DWWA_LEN_16); // (R14)
            if (md == dwwa_pkg::DWWA_MODE_MANUAL)
                ok = ok || (len == dwwa_pkg::DWWA_LEN_32); // (R5)
        end
        else if (W == 20)
            ok = (len == dwwa_pkg::DWWA_LEN_7) ||
                 (len == dwwa_pkg::DWWA_LEN_10) ||
                 (len == dwwa_pkg::DWWA_LEN_20); // (R13)
        return ok;
    endfunction

    // The pattern's top bit sits at the window's top, so its high byte
    // lands in the word that is handed on.
    function automatic logic pat_hit(input logic [2*W-1:0] win,
                                     input logic [2*W-1:0] pat,
                                     input logic [5:0] len);
        logic [2*W-1:0] shifted;
        logic [2*W-1:0] mask;
        shifted = win >> (6'(2 * W) - len);
        mask = ~({(2 * W){1'b1}} << len);
        return (((shifted ^ pat) & mask) == '0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Candidate windows at every bit offset

    logic [3*W-1:0] hist_new;
    logic [W-1:0] hits;
    dwwa_pkg::dwwa_mode_t mode_eff;
    logic len_good;

    // Words enter at the top, so higher bits arrived later
    assign hist_new = {rx_data_i, st_q.hist}; // (R1) (R3)
    assign len_good = len_ok(mode_eff, pat_len_i);

    genvar k;
    generate
        for (k = 0; k < W; k++)
        begin : g_off
            assign hits[k] = len_good &&
                pat_hit(hist_new[k +: 2*W], pattern_i, pat_len_i);
        end
    endgenerate

    always_comb
    begin
        mode_eff = mode_i;
        // Double width has no synchronization machine: fall to manual
        if (DW && mode_i == dwwa_pkg::DWWA_MODE_AUTO) // (R2)
            mode_eff = dwwa_pkg::DWWA_MODE_MANUAL;
        // 20-bit exists only as manual or bit-slip
        if (W == 20 && mode_i == dwwa_pkg::DWWA_MODE_BYPASS) // (R12)
            mode_eff = dwwa_pkg::DWWA_MODE_MANUAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // Alignment state update

    logic accept;
    logic en_rise;
    logic slip_req;
    logic any_hit;
    logic [BW-1:0] first_hit;
    logic push_sync;
    logic push_pdet;
    logic moved;
    dwwa_pkg::dwwa_word_t push_w;
    dwwa_pkg::dwwa_word_t buf_out;

    assign accept = rx_valid_i && rx_ready_o;
    assign en_rise = align_en_i && !st_q.en_prev;
    assign slip_req = slip_i && !st_q.slip_prev;

    always_comb
    begin
        first_hit = '0;
        any_hit = 1'b0;
        for (int i = W - 1; i >= 0; i--)
        begin
            if (hits[i])
            begin
                first_hit = BW'(i);
                any_hit = 1'b1;
            end
        end
    end

    always_comb
    begin
        st_d = st_q;
        push_sync = 1'b0;
        push_pdet = 1'b0;
        moved = 1'b0;
        st_d.en_prev = align_en_i;
        st_d.slip_prev = slip_i;
        if (accept)
            st_d.hist = hist_new[3*W-1:W];
        case (mode_eff)
            dwwa_pkg::DWWA_MODE_MANUAL:
            begin
                if (!LEVEL_EN && en_rise)
                begin
                    st_d.searching = 1'b1; // (R7)
                    st_d.sync_lvl = 1'b0; // (R11)
                end
                if (accept)
                begin
                    if (LEVEL_EN)
                    begin
                        // Level enable: realign only while enable is high
                        if (align_en_i && any_hit && !hits[st_q.bnd]) // (R18)
                        begin
                            st_d.bnd = first_hit;
                            moved = 1'b1;
                        end
                    end
                    else if (st_d.searching && any_hit) // (R5) (R6)
                    begin
                        st_d.bnd = first_hit;
                        st_d.searching = 1'b0;
                        st_d.sync_lvl = DW; // (R11)
                        moved = 1'b1;
                    end
                    push_pdet = hits[st_d.bnd]; // (R9) (R10)
                    push_sync = DW ? st_d.sync_lvl : moved; // (R11) (R18)
                end
            end
            dwwa_pkg::DWWA_MODE_BITSLIP:
            begin
                // Boundary moves only on request, never on a pattern
                if (slip_req) // (R20)
                    st_d.bnd = (st_q.bnd == BW'(W - 1)) ?
                        '0 : st_q.bnd + BW'(1);
                if (accept)
                    push_pdet = hits[st_d.bnd]; // (R17)
            end
            dwwa_pkg::DWWA_MODE_AUTO:
            begin
                if (accept)
                begin
                    if (!st_q.synced)
                    begin
                        if (any_hit && hits[st_q.bnd])
                            st_d.acq_cnt = st_q.acq_cnt + CW'(1);
                        else if (any_hit)
                        begin
                            st_d.bnd = first_hit;
                            st_d.acq_cnt = CW'(1);
                        end
                        if (st_d.acq_cnt >= CW'(ACQ_N))
                        begin
                            st_d.synced = 1'b1;
                            st_d.err_cnt = '0;
                            st_d.good_cnt = '0;
                        end
                    end
                    else if (code_err_i)
                    begin
                        st_d.err_cnt = st_q.err_cnt + CW'(1);
                        st_d.good_cnt = '0;
                        if (st_d.err_cnt >= CW'(LOSE_N))
                        begin
                            st_d.synced = 1'b0;
                            st_d.acq_cnt = '0;
                        end
                    end
                    else if (st_q.err_cnt != '0)
                    begin
                        st_d.good_cnt = st_q.good_cnt + CW'(1);
                        if (st_d.good_cnt >= CW'(GOOD_N))
                        begin
                            st_d.err_cnt = st_q.err_cnt - CW'(1);
                            st_d.good_cnt = '0;
                        end
                    end
                    push_pdet = hits[st_d.bnd];
                    push_sync = st_d.synced; // (R19)
                end
            end
            default:
            begin
                st_d.bnd = '0; // (R4)
            end
        endcase
    end

    always_comb
    begin
        push_w = '0;
        push_w.sync = push_sync;
        push_w.pdet = push_pdet;
        if (mode_eff == dwwa_pkg::DWWA_MODE_BYPASS)
            push_w.data[W-1:0] = rx_data_i; // (R4)
        else
            push_w.data[W-1:0] = hist_new[st_d.bnd + W +: W];
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0; // (R21)
            st_q.searching <= dwwa_pkg::DWWA_RST_SEARCH;
            st_q.sync_lvl <= dwwa_pkg::DWWA_RST_SYNC;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer: status rides with its word, so latency is equal

    dwwa_buf2 #(
        .WIDTH(WORD_W)
    ) u_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(accept), // (R8)
        .in_data_i(push_w),
        .in_ready_o(rx_ready_o),
        .out_valid_o(out_valid_o),
        .out_data_o(buf_out),
        .out_ready_i(out_ready_i)
    );

    assign out_data_o = buf_out.data[W-1:0];
    assign sync_o = buf_out.sync;
    assign pdet_o = buf_out.pdet;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_clears: assert property ( // (R21)
        @(posedge clock_i) disable iff (rst_i)
        $fell(rst_i) |-> (!out_valid_o && !st_q.sync_lvl && st_q.bnd == '0))
        else $error("state not cleared by reset");

    a_search_armed: assert property ( // (R5)
        @(posedge clock_i) disable iff (rst_i)
        $fell(rst_i) |-> st_q.searching)
        else $error("search not armed after reset");

    a_lock_hold: assert property ( // (R6)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_MANUAL && !LEVEL_EN
            && !st_q.searching && !en_rise) |=> $stable(st_q.bnd))
        else $error("locked boundary moved without enable edge");

    a_rise_rearm: assert property ( // (R7)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_MANUAL && !LEVEL_EN && en_rise
            && !(accept && any_hit)) |=> st_q.searching)
        else $error("enable rising edge did not restart search");

    a_sync_drop: assert property ( // (R11)
        @(posedge clock_i) disable iff (rst_i)
        (DW && mode_eff == dwwa_pkg::DWWA_MODE_MANUAL && en_rise
            && !(accept && any_hit)) |=> !st_q.sync_lvl)
        else $error("sync level survived enable rising edge");

    a_lock_detect: assert property ( // (R9)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_MANUAL && !LEVEL_EN && accept
            && (st_q.searching || en_rise) && any_hit) |-> (push_pdet
            && push_w.data[W-1:0] == hist_new[first_hit + W +: W]))
        else $error("first lock lacks detect on its word");

    a_slip_step: assert property ( // (R20)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_BITSLIP && slip_req) |=>
            (st_q.bnd == (($past(st_q.bnd) == BW'(W - 1)) ?
                BW'(0) : $past(st_q.bnd) + BW'(1))))
        else $error("slip did not move boundary by one bit");

    a_slip_nosync: assert property ( // (R17)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_BITSLIP) |-> !push_sync)
        else $error("sync raised in bit-slip mode");

    a_no_dw_auto: assert property ( // (R2)
        @(posedge clock_i) disable iff (rst_i)
        DW |-> !st_q.synced)
        else $error("auto sync active at double width");

    a_bypass_pass: assert property ( // (R4)
        @(posedge clock_i) disable iff (rst_i)
        (mode_eff == dwwa_pkg::DWWA_MODE_BYPASS && accept) |->
            (push_w.data[W-1:0] == rx_data_i && !push_pdet && !push_sync))
        else $error("bypass word altered or flagged");

endmodule
`default_nettype wire

// [dwwa_fabric_model.sv]
// Fabric-side consumer model of the aligned receive stream
`timescale 1ns/1ps
`default_nettype none
module dwwa_fabric_model #(
    parameter int W = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic slow_i,
    input wire logic out_valid_i,
    input wire logic [W-1:0] out_data_i,
    input wire logic sync_i,
    input wire logic pdet_i,
    output logic out_ready_o
);
    dwwa_pkg::dwwa_word_t got_q[$];
    logic toggle_q;

    ////////////////////////////////////////////////////////////////////////
    // Ready is a register, so a hold request bites one clock late, as a
    // real pipelined consumer would; slow mode accepts every other clock
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            toggle_q <= 1'h0;
            out_ready_o <= 1'h0;
        end
        else
        begin
            toggle_q <= ~toggle_q;
            out_ready_o <= ~hold_i && (~slow_i || toggle_q);
            if (out_valid_i && out_ready_o)
            begin
                got_q.push_back(dwwa_pkg::dwwa_word_t'{data: 20'(out_data_i),
                    sync: sync_i, pdet: pdet_i});
            end
        end
    end
endmodule
`default_nettype wire

// [dwwa_word_aligner_tb.sv]
// Self-checking testbench of the receive word aligner
`timescale 1ns/1ps
`default_nettype none
module dwwa_word_aligner_tb;
    localparam int W = 16;
    localparam logic [15:0] PAT = 16'hF628;
    localparam int WATCH_CYCLES = 20000;
    logic clk = 1'h0;
    logic rst = 1'h1;
    dwwa_pkg::dwwa_mode_t mode = dwwa_pkg::DWWA_MODE_MANUAL;
    logic align_en = 1'h0;
    logic slip = 1'h0;
    logic rx_valid = 1'h0;
    logic [W-1:0] rx_data = 16'h0000;
    logic hold = 1'h0;
    logic slow = 1'h0;
    logic [5:0] pat_len = dwwa_pkg::DWWA_LEN_16;
    logic rx_ready, out_valid, out_ready, sync, pdet;
    logic [W-1:0] out_data;
    int errors = 0;
    int checks_done = 0;
    int refused;
    int bnd;
    logic [W-1:0] h0, h1;
    logic srch, syn;
    dwwa_pkg::dwwa_word_t exp_q[$];

    always #4 clk = ~clk;

    dwwa_word_aligner #(.W(W), .ACQ_N(2), .LOSE_N(2), .GOOD_N(2))
    u_dwwa_word_aligner (.clock_i(clk), .rst_i(rst), .mode_i(mode),
        .pattern_i({16'h0000, PAT}), .pat_len_i(pat_len),
        .align_en_i(align_en), .slip_i(slip), .code_err_i(1'h0),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
        .out_valid_o(out_valid), .out_ready_i(out_ready),
        .out_data_o(out_data), .sync_o(sync), .pdet_o(pdet));

    dwwa_fabric_model #(.W(W)) u_dwwa_fabric_model (.clock_i(clk),
        .rst_i(rst), .hold_i(hold), .slow_i(slow), .out_valid_i(out_valid),
        .out_data_i(out_data), .sync_i(sync), .pdet_i(pdet),
        .out_ready_o(out_ready));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic hit(input logic [3*W-1:0] win, input int b);
        // Only the 16-bit length is modelled; 20 is refused at this width
        return pat_len == dwwa_pkg::DWWA_LEN_16 && win[b+W +: W] === PAT;
    endfunction

    task automatic do_reset(input dwwa_pkg::dwwa_mode_t m);
        rst <= 1'h1;
        mode <= m;
        rx_valid <= 1'h0;
        repeat (16) @(posedge clk);
        check("sync in reset", 32'h0, sync);
        check("pdet in reset", 32'h0, pdet);
        check("valid in reset", 32'h0, out_valid);
        rst <= 1'h0;
        h0 = 16'h0000;
        h1 = 16'h0000;
        bnd = 0;
        srch = 1'h1;
        syn = 1'h0;
        exp_q.delete();
        u_dwwa_fabric_model.got_q.delete();
    endtask

    // Leaves valid high so that back-to-back words need no gap
    task automatic send(input logic [W-1:0] d);
        logic [3*W-1:0] win;
        logic pd;
        int n;
        rx_valid <= 1'h1;
        rx_data <= d;
        n = 0;
        @(posedge clk);
        while (rx_ready !== 1'h1 && n < 200)
        begin
            refused++;
            n++;
            @(posedge clk);
        end
        check("input accepted", 32'h1, rx_ready);
        win = {d, h1, h0};
        h0 = h1;
        h1 = d;
        pd = hit(win, bnd);
        if ((mode == dwwa_pkg::DWWA_MODE_MANUAL ||
             mode == dwwa_pkg::DWWA_MODE_AUTO) && srch)
        begin
            // Lowest offset wins, so scan downwards and keep the last hit
            for (int b = W - 1; b >= 0; b--)
            begin
                if (hit(win, b))
                begin
                    bnd = b;
                    srch = 1'h0;
                    syn = 1'h1;
                    pd = 1'h1;
                end
            end
        end
        if (mode == dwwa_pkg::DWWA_MODE_BYPASS)
            exp_q.push_back(dwwa_pkg::dwwa_word_t'{data: 20'(d), sync: 1'h0,
                pdet: 1'h0});
        else
            exp_q.push_back(dwwa_pkg::dwwa_word_t'{data: 20'(win[bnd+W +: W]),
                sync: syn, pdet: pd});
    endtask

    task automatic send3(input logic [3*W-1:0] s);
        send(s[15:0]);
        send(s[31:16]);
        send(s[47:32]);
    endtask

    task automatic drain(input string what);
        int n;
        rx_valid <= 1'h0;
        n = 0;
        while (u_dwwa_fabric_model.got_q.size() < exp_q.size() && n < 400)
        begin
            n++;
            @(posedge clk);
        end
        check({what, " count"}, exp_q.size(),
              u_dwwa_fabric_model.got_q.size());
        foreach (exp_q[i])
        begin
            if (i < u_dwwa_fabric_model.got_q.size())
                check({what, " word"}, exp_q[i], u_dwwa_fabric_model.got_q[i]);
        end
        exp_q.delete();
        u_dwwa_fabric_model.got_q.delete();
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_manual();
        do_reset(dwwa_pkg::DWWA_MODE_MANUAL);
        slow <= 1'h1;
        send(16'h1234);
        send3(48'(PAT) << 21);
        send3(48'(PAT) << 25);
        send3(48'(PAT) << 21);
        drain("manual lock");
        slow <= 1'h0;
        align_en <= 1'h1;
        srch = 1'h1;
        syn = 1'h0;
        repeat (3) @(posedge clk);
        align_en <= 1'h0;
        repeat (2) @(posedge clk);
        send(16'h0F0F);
        send3(48'(PAT) << 25);
        drain("manual realign");
        $display("test manual alignment done");
    endtask

    task automatic t_auto();
        // Double width has no sync machine, so auto must act as manual
        do_reset(dwwa_pkg::DWWA_MODE_AUTO);
        pat_len <= dwwa_pkg::DWWA_LEN_20;
        send3(48'(PAT) << 21);
        pat_len <= dwwa_pkg::DWWA_LEN_16;
        send3(48'(PAT) << 25);
        drain("auto as manual");
        $display("test auto fallback done");
    endtask

    task automatic t_bitslip();
        do_reset(dwwa_pkg::DWWA_MODE_BITSLIP);
        send3(48'(PAT) << 21);
        drain("slip unshifted");
        // Wraps once round the word to reach offset five
        for (int i = 0; i < 21; i++)
        begin
            slip <= 1'h1;
            @(posedge clk);
            slip <= 1'h0;
            repeat (2) @(posedge clk);
            bnd = (bnd + 1) % W;
        end
        hold <= 1'h1;
        fork
            begin
                repeat (12) @(posedge clk);
                hold <= 1'h0;
            end
        join_none
        refused = 0;
        send(16'hA5C3);
        send3(48'(PAT) << 21);
        send(16'h3C5A);
        check("input refused while stalled", 32'h1, refused > 0);
        drain("slip shifted");
        $display("test bit slip done");
    endtask

    task automatic t_bypass();
        do_reset(dwwa_pkg::DWWA_MODE_BYPASS);
        send(PAT);
        send(16'h0001);
        send(16'hFFFF);
        drain("bypass");
        $display("test bypass done");
    endtask

    initial
    begin
        t_manual();
        t_auto();
        t_bitslip();
        t_bypass();
        finish_test();
    end

    initial
    begin
        repeat (WATCH_CYCLES) @(posedge clk);
        errors++;
        $display("[ERR] run length expected end seen watchdog");
        finish_test();
    end
endmodule
`default_nettype wire
